// ### common/tebc_pkg.sv
// Constants for the translation enable / bypass control block.
// Assumes an AXI4-Lite register slave with 32-bit data and a single core clock.
// How it works
// - Reset disabled; bypass or abort per abort flag
// - Per-state translate enable; secure only if present
// - Disabled: abort if flag set, else bypass attrs
// - Disabled state never looks up stream table
// - Disabled: page requests denied regardless of enable
// - Disabled: no software or ATS translations
// - Registers stay accessible while disabled
// - Commands run when queue enabled, even disabled
// - Disabled: no new events; drain buffered ones
// - Enabled state uses stream-table translation flow
// - No secure interface: outgoing NS forced 1
// - Both disabled: per-state bypass attributes incl NS
// - Secure only enabled: nonsecure bypass or abort
// - Nonsecure only enabled: secure bypass or abort
// - Enable change needs no cache invalidation
// - Invalidate-all bit reads 1 until done
// - Nonsecure access to cache-init register optional
// - Bypass TLB entries invisible, need no invalidation
// - Secure stream flag selects secure table
// - Nonsecure streams force requested attribute NS
package tebc_pkg;
    localparam logic [7:0] TEBC_OFF_NS_CTRL   = 8'h00;
    localparam logic [7:0] TEBC_OFF_S_CTRL    = 8'h04;
    localparam logic [7:0] TEBC_OFF_NS_BYPASS = 8'h08;
    localparam logic [7:0] TEBC_OFF_S_BYPASS  = 8'h0C;
    localparam logic [7:0] TEBC_OFF_INIT      = 8'h10;
    localparam logic [7:0] TEBC_OFF_STATUS    = 8'h14;
    localparam logic [7:0] TEBC_OFF_NS_TABLE  = 8'h18;
    localparam logic [7:0] TEBC_OFF_S_TABLE   = 8'h1C;
    // Control register bits
    localparam int TEBC_BIT_EN    = 0;
    localparam int TEBC_BIT_CMDQ  = 1;
    localparam int TEBC_BIT_EVTQ  = 2;
    localparam int TEBC_BIT_PRIQ  = 3;
    // Bypass register bits
    localparam int TEBC_BIT_ABORT = 31;
    localparam int TEBC_BIT_NS    = 0;
    localparam int TEBC_ATTR_W    = 8;
    localparam logic [31:0] TEBC_BYPASS_RST = 32'h0000_0000;
    localparam logic [31:0] TEBC_CTRL_RST   = 32'h0000_0000;
    localparam int TEBC_INV_CYCLES = 16;
    localparam logic [1:0] TEBC_RESP_OKAY   = 2'h0;
    localparam logic [1:0] TEBC_RESP_SLVERR = 2'h2;
    typedef enum logic [2:0] {
        TEBC_INV_IDLE = 3'h1,
        TEBC_INV_RUN  = 3'h2,
        TEBC_INV_DONE = 3'h4
    } tebc_inv_e;
endpackage

// ### src/tebc_ctrl.sv
// Global enable, bypass and abort decision for one transaction path plus registers.
// Assumes synchronous inputs on core_clk; the translation engine sits downstream.
//
// Register access over AXI4-Lite and the register offsets were left to the implementer.
module tebc_ctrl
    import tebc_pkg::*;
#(
    parameter bit SECURE_PRESENT = 1'b1,
    parameter bit NS_ABORT_RST   = 1'b0,
    parameter bit S_ABORT_RST    = 1'b0
) (
    input  wire logic                   core_clk,
    input  wire logic                   rst_n,
    input  wire logic [7:0]             s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    input  wire logic [7:0]             s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    input  wire logic                   txn_valid,
    input  wire logic                   secure_stream_flag,
    input  wire logic                   requested_security_attribute,
    output logic                        txn_translate,
    output logic                        txn_bypass,
    output logic                        txn_abort,
    output logic                        txn_secure_table,
    output logic                        out_ns,
    output logic [TEBC_ATTR_W-1:0]      out_attr,
    output logic                        table_lookup_allow,
    output logic                        page_request_allow,
    output logic                        xlate_request_allow,
    output logic                        ns_cmd_run,
    output logic                        s_cmd_run,
    output logic                        ns_event_record,
    output logic                        s_event_record,
    output logic                        ns_event_drain,
    output logic                        s_event_drain,
    output logic                        invalidate_all_req,
    input  wire logic                   invalidate_all_done,
    input  wire logic                   ns_init_access
);
    logic [31:0] ns_ctrl_r, s_ctrl_r, ns_bypass_r, s_bypass_r, ns_table_r, s_table_r;
    logic        aw_held_r, w_held_r;
    logic [7:0]  aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0]  w_strb_r;
    tebc_inv_e   inv_state_r;
    logic [4:0]  inv_cnt_r;
    logic        ns_en, s_en, do_write, wr_ok, rd_ok;
    logic [31:0] rd_val;

    // Effective enables; the secure one is absent without secure support
    assign ns_en = ns_ctrl_r[TEBC_BIT_EN];
    assign s_en  = SECURE_PRESENT & s_ctrl_r[TEBC_BIT_EN];

    // Write channel capture; address and data may arrive in either order
    assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
    assign s_axi_wready  = !w_held_r && !s_axi_bvalid;
    assign do_write      = aw_held_r && w_held_r && !s_axi_bvalid;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_held_r <= 1'b0;
            w_held_r  <= 1'b0;
            aw_addr_r <= 8'h00;
            w_data_r  <= 32'h0000_0000;
            w_strb_r  <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end else if (do_write) begin
                aw_held_r <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end else if (do_write) begin
                w_held_r <= 1'b0;
            end
        end
    end

    // Byte-lane merge of write data into an old value
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nv,
                                          input logic [3:0] be);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) res[i*8 +: 8] = nv[i*8 +: 8];
        end
        return res;
    endfunction

    // Init register access: secure side always, nonsecure only when the system allows
    logic init_ok;
    assign init_ok = SECURE_PRESENT | ns_init_access;

    // Decode of the written address
    always_comb begin
        if (aw_addr_r == TEBC_OFF_NS_CTRL || aw_addr_r == TEBC_OFF_NS_BYPASS
            || aw_addr_r == TEBC_OFF_NS_TABLE || aw_addr_r == TEBC_OFF_STATUS) begin
            wr_ok = 1'b1;
        end else if (aw_addr_r == TEBC_OFF_S_CTRL || aw_addr_r == TEBC_OFF_S_BYPASS
                     || aw_addr_r == TEBC_OFF_S_TABLE) begin
            wr_ok = SECURE_PRESENT;
        end else if (aw_addr_r == TEBC_OFF_INIT) begin
            wr_ok = init_ok;
        end else begin
            wr_ok = 1'b0;
        end
    end

    // Programming registers; writable whatever the enable state
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ns_ctrl_r   <= TEBC_CTRL_RST;
            s_ctrl_r    <= TEBC_CTRL_RST;
            // Abort flag reset value is a strap: bypass or abort from power-up
            ns_bypass_r <= TEBC_BYPASS_RST | {NS_ABORT_RST, 31'h0000_0000};
            s_bypass_r  <= TEBC_BYPASS_RST | {S_ABORT_RST, 31'h0000_0000};
            ns_table_r  <= 32'h0000_0000;
            s_table_r   <= 32'h0000_0000;
        end else if (do_write && wr_ok) begin
            if (aw_addr_r == TEBC_OFF_NS_CTRL) begin
                ns_ctrl_r <= merge(ns_ctrl_r, w_data_r, w_strb_r) & 32'h0000_000F;
            end else if (aw_addr_r == TEBC_OFF_S_CTRL) begin
                s_ctrl_r <= merge(s_ctrl_r, w_data_r, w_strb_r) & 32'h0000_000F;
            end else if (aw_addr_r == TEBC_OFF_NS_BYPASS) begin
                ns_bypass_r <= merge(ns_bypass_r, w_data_r, w_strb_r);
            end else if (aw_addr_r == TEBC_OFF_S_BYPASS) begin
                s_bypass_r <= merge(s_bypass_r, w_data_r, w_strb_r);
            end else if (aw_addr_r == TEBC_OFF_NS_TABLE) begin
                ns_table_r <= merge(ns_table_r, w_data_r, w_strb_r);
            end else if (aw_addr_r == TEBC_OFF_S_TABLE) begin
                s_table_r <= merge(s_table_r, w_data_r, w_strb_r);
            end
        end
    end

    // Write response; unmapped or barred addresses answer SLVERR
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= TEBC_RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? TEBC_RESP_OKAY : TEBC_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Invalidate-all sequencer: bit reads 1 from the write until the caches report done
    logic inv_start;
    assign inv_start = do_write && wr_ok && aw_addr_r == TEBC_OFF_INIT && w_strb_r[0]
                       && w_data_r[0];
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            inv_state_r <= TEBC_INV_IDLE;
            inv_cnt_r   <= 5'h00;
        end else begin
            case (inv_state_r)
                TEBC_INV_IDLE: begin
                    if (inv_start) begin
                        inv_state_r <= TEBC_INV_RUN;
                        inv_cnt_r   <= 5'h00;
                    end
                end
                TEBC_INV_RUN: begin
                    if (inv_cnt_r != 5'(TEBC_INV_CYCLES)) inv_cnt_r <= inv_cnt_r + 5'h01;
                    // A fresh write in the finishing cycle wins and keeps the run going
                    if (invalidate_all_done && !inv_start) inv_state_r <= TEBC_INV_DONE;
                end
                TEBC_INV_DONE: begin
                    inv_cnt_r   <= 5'h00;
                    inv_state_r <= inv_start ? TEBC_INV_RUN : TEBC_INV_IDLE;
                end
                default: inv_state_r <= TEBC_INV_IDLE;
            endcase
        end
    end
    // Request held to the cache side for the whole run; bypass-time TLB entries also go
    assign invalidate_all_req = (inv_state_r == TEBC_INV_RUN);

    // Read channel; one read at a time, data registered
    always_comb begin
        rd_ok  = 1'b1;
        rd_val = 32'h0000_0000;
        if (s_axi_araddr == TEBC_OFF_NS_CTRL) begin
            rd_val = ns_ctrl_r;
        end else if (s_axi_araddr == TEBC_OFF_S_CTRL) begin
            rd_val = SECURE_PRESENT ? s_ctrl_r : 32'h0000_0000;
        end else if (s_axi_araddr == TEBC_OFF_NS_BYPASS) begin
            rd_val = ns_bypass_r;
        end else if (s_axi_araddr == TEBC_OFF_S_BYPASS) begin
            rd_val = SECURE_PRESENT ? s_bypass_r : 32'h0000_0000;
        end else if (s_axi_araddr == TEBC_OFF_INIT) begin
            rd_ok  = init_ok;
            rd_val = {31'h0, inv_state_r != TEBC_INV_IDLE};
        end else if (s_axi_araddr == TEBC_OFF_STATUS) begin
            rd_val = {28'h0, SECURE_PRESENT, s_en, ns_en, inv_state_r != TEBC_INV_IDLE};
        end else if (s_axi_araddr == TEBC_OFF_NS_TABLE) begin
            rd_val = ns_table_r;
        end else if (s_axi_araddr == TEBC_OFF_S_TABLE) begin
            rd_val = SECURE_PRESENT ? s_table_r : 32'h0000_0000;
        end else begin
            rd_ok = 1'b0;
        end
    end
    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= TEBC_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_val;
            s_axi_rresp  <= rd_ok ? TEBC_RESP_OKAY : TEBC_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Transaction decision; combinational so the steering tracks each beat
    logic sec, st_en, st_abort;
    logic [31:0] st_bypass;
    always_comb begin
        sec       = SECURE_PRESENT & secure_stream_flag;
        st_en     = sec ? s_en : ns_en;
        st_bypass = sec ? s_bypass_r : ns_bypass_r;
        st_abort  = st_bypass[TEBC_BIT_ABORT];
        // Enabled state: stream table picks the flow disabled
        txn_translate    = txn_valid & st_en;
        txn_abort        = txn_valid & !st_en & st_abort;
        txn_bypass       = txn_valid & !st_en & !st_abort;
        txn_secure_table = sec;
        out_attr         = st_bypass[TEBC_ATTR_W-1:0];
        // Bypass NS comes from the state's bypass setting; nonsecure streams always NS
        if (!SECURE_PRESENT || !sec) begin
            out_ns = 1'b1;
        end else if (st_en) begin
            out_ns = requested_security_attribute;
        end else begin
            out_ns = st_bypass[TEBC_BIT_NS];
        end
        // No lookups, page requests or translation services while disabled
        table_lookup_allow  = txn_valid & st_en;
        page_request_allow  = ns_en & ns_ctrl_r[TEBC_BIT_PRIQ];
        xlate_request_allow = st_en;
    end

    // Command run and event drain stay live when translation is off; event recording does not
    assign ns_cmd_run      = ns_ctrl_r[TEBC_BIT_CMDQ];
    assign s_cmd_run       = s_ctrl_r[TEBC_BIT_CMDQ] & SECURE_PRESENT;
    assign ns_event_record = ns_en & ns_ctrl_r[TEBC_BIT_EVTQ];
    assign s_event_record  = s_en & s_ctrl_r[TEBC_BIT_EVTQ];
    assign ns_event_drain  = ns_ctrl_r[TEBC_BIT_EVTQ];
    assign s_event_drain   = s_ctrl_r[TEBC_BIT_EVTQ] & SECURE_PRESENT;
    // Enable changes never trigger invalidation by themselves

    // Abort flags after reset follow the straps, caught after release
    logic straps_done_r;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) straps_done_r <= 1'b0;
        else straps_done_r <= 1'b1;
    end

    // Checks on the decision, reset and invalidate paths
    a_reset_disabled: assert property (@(posedge core_clk) disable iff (!rst_n)
        !straps_done_r |-> !ns_en && !s_en) else $error("enable set at reset");

    a_reset_abort: assert property (@(posedge core_clk) disable iff (!rst_n)
        !straps_done_r |-> ns_bypass_r[TEBC_BIT_ABORT] == NS_ABORT_RST
        && s_bypass_r[TEBC_BIT_ABORT] == S_ABORT_RST) else $error("abort flag reset wrong");

    a_abort_path: assert property (@(posedge core_clk) disable iff (!rst_n)
        txn_valid && !ns_en && !secure_stream_flag && ns_bypass_r[TEBC_BIT_ABORT]
        |-> txn_abort && !txn_bypass) else $error("disabled abort missed");

    a_ns_bypass: assert property (@(posedge core_clk) disable iff (!rst_n)
        txn_valid && !secure_stream_flag && !ns_en && !ns_bypass_r[TEBC_BIT_ABORT]
        |-> txn_bypass && out_attr == ns_bypass_r[TEBC_ATTR_W-1:0])
        else $error("ns bypass attributes wrong");

    a_s_bypass: assert property (@(posedge core_clk) disable iff (!rst_n)
        txn_valid && SECURE_PRESENT && secure_stream_flag && !s_en
        && !s_bypass_r[TEBC_BIT_ABORT] |-> txn_bypass && out_ns == s_bypass_r[TEBC_BIT_NS])
        else $error("secure bypass wrong");

    a_ns_translate: assert property (@(posedge core_clk) disable iff (!rst_n)
        txn_valid && !secure_stream_flag && ns_en |-> txn_translate)
        else $error("enabled ns not translated");

    a_no_lookup: assert property (@(posedge core_clk) disable iff (!rst_n)
        table_lookup_allow |-> txn_translate) else $error("lookup while disabled");

    a_pri_denied: assert property (@(posedge core_clk) disable iff (!rst_n)
        !ns_en |-> !page_request_allow) else $error("page request allowed");

    a_xlate_off: assert property (@(posedge core_clk) disable iff (!rst_n)
        txn_valid && !txn_translate |-> !xlate_request_allow)
        else $error("translation service while disabled");

    a_event_quiet: assert property (@(posedge core_clk) disable iff (!rst_n)
        !ns_en |-> !ns_event_record) else $error("event recorded while disabled");

    a_ns_forced: assert property (@(posedge core_clk) disable iff (!rst_n)
        txn_valid && !secure_stream_flag |-> out_ns) else $error("ns stream not NS");

    a_no_secure_ns: assert property (@(posedge core_clk) disable iff (!rst_n)
        txn_valid && !SECURE_PRESENT |-> out_ns) else $error("NS not forced");

    a_secure_table: assert property (@(posedge core_clk) disable iff (!rst_n)
        txn_valid |-> txn_secure_table == (SECURE_PRESENT && secure_stream_flag))
        else $error("wrong table selected");

    a_inv_busy: assert property (@(posedge core_clk) disable iff (!rst_n)
        inv_start |=> invalidate_all_req [*2]) else $error("invalidate not held");

    a_inv_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
        invalidate_all_req && invalidate_all_done && !inv_start |=> !invalidate_all_req)
        else $error("invalidate stuck");

    a_no_auto_inv: assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(invalidate_all_req) |-> $past(inv_start)) else $error("invalidate unasked");

    a_cmd_live: assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(ns_ctrl_r[TEBC_BIT_CMDQ]) |-> ns_cmd_run) else $error("cmd queue idle");

    a_one_kind: assert property (@(posedge core_clk) disable iff (!rst_n)
        txn_valid |-> $onehot({txn_translate, txn_bypass, txn_abort}))
        else $error("transaction not steered once");
endmodule

// ### tb/tebc_inv_agent.sv
// Cache invalidation engine that answers the block's invalidate-all request.
// Assumes req is a level held until done is seen; delay sets prompt or slow answers.
module tebc_inv_agent (
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic       invalidate_all_req,
    input  wire logic [7:0] delay,
    output logic            invalidate_all_done
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt_r;

    // Count out the walk, then give one done pulse; the count restarts so a slow
    // req drop cannot trigger a second pulse unless delay is zero
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r               <= 8'h00;
            invalidate_all_done <= 1'b0;
        end else begin
            invalidate_all_done <= 1'b0;
            if (!invalidate_all_req || invalidate_all_done) begin
                cnt_r <= 8'h00;
            end else if (cnt_r == delay) begin
                invalidate_all_done <= 1'b1;
            end else begin
                cnt_r <= cnt_r + 8'h01;
            end
        end
    end
endmodule

// ### tb/tb_translation_enable_bypass_ctrl.sv
// Self-checking bench for the enable, bypass and abort control block.
// Assumes the design's AXI4-Lite timing, register map and reset-to-bypass values.
module tb_translation_enable_bypass_ctrl
    import tebc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk, rst_n, awv, wv, bry, arv, rry, tv, sflag, rsa, nia;
    logic        awrdy, wrdy, bv, arrdy, rv, ireq, done;
    logic        tr, by, ab, st, ons, look, xl, pra, ncr, scr, ner, ser, ned, sed, n_ns;
    logic [7:0]  awa, ara, inv_dly, attr;
    logic [31:0] wd, rdat, d;
    logic [3:0]  ws;
    logic [1:0]  br, rr, r, en, n_br;
    int          err_count, compares, n;

    // Full-featured instance plus one without the secure interface on the same bus
    tebc_ctrl DUT (.core_clk(core_clk), .rst_n(rst_n), .s_axi_awaddr(awa),
        .s_axi_awvalid(awv), .s_axi_awready(awrdy), .s_axi_wdata(wd), .s_axi_wstrb(ws),
        .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(br), .s_axi_bvalid(bv),
        .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arrdy), .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv),
        .s_axi_rready(rry), .txn_valid(tv), .secure_stream_flag(sflag),
        .requested_security_attribute(rsa), .txn_translate(tr), .txn_bypass(by),
        .txn_abort(ab), .txn_secure_table(st), .out_ns(ons), .out_attr(attr),
        .table_lookup_allow(look), .page_request_allow(pra), .xlate_request_allow(xl),
        .ns_cmd_run(ncr), .s_cmd_run(scr), .ns_event_record(ner), .s_event_record(ser),
        .ns_event_drain(ned), .s_event_drain(sed), .invalidate_all_req(ireq),
        .invalidate_all_done(done), .ns_init_access(1'b0));
    tebc_ctrl #(.SECURE_PRESENT(1'b0)) dut_nosec (.core_clk(core_clk), .rst_n(rst_n),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(), .s_axi_wdata(wd),
        .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(), .s_axi_bresp(n_br),
        .s_axi_bvalid(), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(), .s_axi_rdata(), .s_axi_rresp(), .s_axi_rvalid(),
        .s_axi_rready(rry), .txn_valid(tv), .secure_stream_flag(sflag),
        .requested_security_attribute(rsa), .txn_translate(), .txn_bypass(),
        .txn_abort(), .txn_secure_table(), .out_ns(n_ns), .out_attr(),
        .table_lookup_allow(), .page_request_allow(), .xlate_request_allow(),
        .ns_cmd_run(), .s_cmd_run(), .ns_event_record(), .s_event_record(),
        .ns_event_drain(), .s_event_drain(), .invalidate_all_req(),
        .invalidate_all_done(done), .ns_init_access(nia));
    tebc_inv_agent inv (.core_clk(core_clk), .rst_n(rst_n), .invalidate_all_req(ireq),
        .delay(inv_dly), .invalidate_all_done(done));

    // Free-running core clock
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic conclude();
        if (err_count == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask

    // Handshakes are judged at the falling edge, where inputs and comb readies are settled
    task automatic axw(input logic [7:0] a, input logic [31:0] dat, output logic [1:0] rs);
        logic ha, hw, got;
        int   k;
        @(posedge core_clk);
        awa <= a;
        wd  <= dat;
        awv <= 1'b1;
        wv  <= 1'b1;
        bry <= 1'b1;
        got = 1'b0;
        k = 0;
        while (!got && k < 50) begin
            @(negedge core_clk);
            ha = awv && awrdy;
            hw = wv && wrdy;
            got = bv;
            rs = br;
            k++;
            @(posedge core_clk);
            if (ha) awv <= 1'b0;
            if (hw) wv <= 1'b0;
            if (got) bry <= 1'b0;
        end
        chk(32'h1, {31'h0, got});
    endtask

    task automatic axr(input logic [7:0] a, output logic [31:0] dat, output logic [1:0] rs);
        logic hs, got;
        int   k;
        @(posedge core_clk);
        ara <= a;
        arv <= 1'b1;
        rry <= 1'b1;
        got = 1'b0;
        k = 0;
        while (!got && k < 50) begin
            @(negedge core_clk);
            hs = arv && arrdy;
            got = rv;
            dat = rdat;
            rs = rr;
            k++;
            @(posedge core_clk);
            if (hs) arv <= 1'b0;
            if (got) rry <= 1'b0;
        end
        chk(32'h1, {31'h0, got});
    endtask

    task automatic wreg(input logic [7:0] a, input logic [31:0] dat, input logic [1:0] e);
        logic [1:0] rs;
        axw(a, dat, rs);
        chk({30'h0, e}, {30'h0, rs});
    endtask

    // Data is only compared on an OKAY answer; an error read carries no defined word
    task automatic rreg(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        logic [31:0] dat;
        logic [1:0]  rs;
        axr(a, dat, rs);
        chk({30'h0, er}, {30'h0, rs});
        if (er == TEBC_RESP_OKAY) chk(e, dat);
    endtask

    // Expected word: {translate,bypass,abort,table,lookup,xlate}, NS, attributes
    task automatic txc(input logic f, input logic q, input logic [14:0] e, input logic full);
        @(posedge core_clk);
        tv    <= 1'b1;
        sflag <= f;
        rsa   <= q;
        @(negedge core_clk);
        if (full) chk({17'h0, e}, {17'h0, tr, by, ab, st, look, xl, ons, attr});
        else chk({26'h0, e[14:9]}, {26'h0, tr, by, ab, st, look, xl});
    endtask

    // Hang guard, far beyond the few hundred cycles the sequence needs
    initial begin
        repeat (20000) @(posedge core_clk);
        err_count++;
        conclude();
    end

    // Main sequence
    initial begin
        {rst_n, awv, wv, bry, arv, rry, tv, sflag, rsa, nia} = 10'h000;
        {awa, ara, wd} = 48'h0;
        ws = 4'hF;
        inv_dly = 8'h06;
        err_count = 0;
        compares = 0;
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            rreg(8'(i * 4), (i == 5) ? 32'h8 : 32'h0, TEBC_RESP_OKAY);
        end
        txc(1'b0, 1'b0, {6'b010000, 1'b1, 8'h00}, 1'b1);
        txc(1'b1, 1'b0, {6'b010100, 1'b0, 8'h00}, 1'b1);
        wreg(8'h08, 32'h0000_00A4, TEBC_RESP_OKAY);
        wreg(8'h0C, 32'h0000_003D, TEBC_RESP_OKAY);
        rreg(8'h0C, 32'h0000_003D, TEBC_RESP_OKAY);
        txc(1'b0, 1'b0, {6'b010000, 1'b1, 8'hA4}, 1'b1);
        txc(1'b1, 1'b0, {6'b010100, 1'b1, 8'h3D}, 1'b1);
        wreg(8'h08, 32'h8000_00A4, TEBC_RESP_OKAY);
        txc(1'b0, 1'b0, {6'b001000, 9'h0}, 1'b0);
        wreg(8'h08, 32'h0000_00A4, TEBC_RESP_OKAY);
        wreg(8'h0C, 32'h8000_003D, TEBC_RESP_OKAY);
        wreg(8'h18, 32'h0000_1000, TEBC_RESP_OKAY);
        wreg(8'h1C, 32'h0000_2000, TEBC_RESP_OKAY);
        rreg(8'h18, 32'h0000_1000, TEBC_RESP_OKAY);
        // One prompt and one slow invalidation, each polled until the bit clears
        for (int k = 0; k < 2; k++) begin
            inv_dly <= (k == 0) ? 8'h06 : 8'h0E;
            nia     <= (k == 1);
            wreg(8'h10, 32'h1, TEBC_RESP_OKAY);
            chk(32'h1, {31'h0, ireq});
            chk({30'h0, (k == 1) ? TEBC_RESP_OKAY : TEBC_RESP_SLVERR}, {30'h0, n_br});
            rreg(8'h10, 32'h1, TEBC_RESP_OKAY);
            n = 0;
            do begin
                axr(8'h10, d, r);
                n++;
            end while (d[0] !== 1'b0 && n < 20);
            chk(32'h0, {31'h0, d[0]});
            chk(32'h0, {31'h0, ireq});
        end
        // All four enable pairings with queues on; secure side aborts when disabled
        for (int i = 0; i < 4; i++) begin
            en = i[1:0];
            wreg(8'h00, 32'h0000_000E | 32'(en[0]), TEBC_RESP_OKAY);
            wreg(8'h04, 32'h0000_000E | 32'(en[1]), TEBC_RESP_OKAY);
            txc(1'b0, 1'b0, en[0] ? {6'b100011, 9'h0} : {6'b010000, 1'b1, 8'hA4}, !en[0]);
            txc(1'b1, 1'b1, en[1] ? {6'b100111, 9'h0} : {6'b001100, 9'h0}, 1'b0);
            chk(32'h1, {31'h0, n_ns});
            chk({25'h0, en[0], en[0], en[1], 4'hF}, {25'h0, pra, ner, ser, ned, sed, ncr, scr});
            rreg(8'h14, {28'h0, 1'b1, en[1], en[0], 1'b0}, TEBC_RESP_OKAY);
        end
        wreg(8'h40, 32'h1, TEBC_RESP_SLVERR);
        rreg(8'h40, 32'h0, TEBC_RESP_SLVERR);
        conclude();
    end
endmodule
